// ==== pdmsc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module pdmsc_host (
  // Register port
  input  wire logic       CLK,
  output logic      [7:0] REG_ADDR,
  output logic            REG_WR,
  output logic      [7:0] REG_WDATA,
  output logic            REG_RD,
  input  wire logic [7:0] REG_RDATA,
  // Sleep clear
  output logic            SLEEP_FLAG_CLR
);
  initial {REG_ADDR, REG_WR, REG_WDATA, REG_RD, SLEEP_FLAG_CLR} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK) {REG_ADDR, REG_WDATA, REG_WR} = {a, d, 1'h1};
    @(negedge CLK) {REG_WDATA, REG_WR} = {~d, 1'h0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge CLK) {REG_ADDR, REG_RD} = {a, 1'h1};
    @(negedge CLK) REG_RD = 1'h0;
    d = REG_RDATA;
  endtask
  task automatic clr;
    @(negedge CLK) SLEEP_FLAG_CLR = 1'h1;
    @(negedge CLK) SLEEP_FLAG_CLR = 1'h0;
  endtask
endmodule
`default_nettype wire

// ==== pdmsc_map.svh ====
`ifndef PDMSC_MAP_SVH
`define PDMSC_MAP_SVH

// Register offsets
`define PDMSC_OFS_DATA_C_LO   8'h94
`define PDMSC_OFS_DATA_C_HI   8'h95
`define PDMSC_OFS_DATA_R_LO   8'h96
`define PDMSC_OFS_DATA_R_HI   8'h97
`define PDMSC_OFS_DATA_G_LO   8'h98
`define PDMSC_OFS_DATA_G_HI   8'h99
`define PDMSC_OFS_DATA_B_LO   8'h9A
`define PDMSC_OFS_DATA_B_HI   8'h9B
`define PDMSC_OFS_PROX_LO     8'h9C
`define PDMSC_OFS_PROX_HI     8'h9D
`define PDMSC_OFS_MASK_CFG    8'h9F
`define PDMSC_OFS_SLEEP_CFG   8'hAB

// Field positions
`define PDMSC_BIT_EAST        7
`define PDMSC_BIT_WEST        6
`define PDMSC_BIT_SOUTH       5
`define PDMSC_BIT_NORTH       4
`define PDMSC_BIT_AMB_REDUCE  3
`define PDMSC_BIT_IR_ROUTE    6
`define PDMSC_BIT_SLEEP_IRQ   4

// Writable bits, reserved bits stay zero
`define PDMSC_MASK_CFG_WMASK  8'hF8
`define PDMSC_SLEEP_CFG_WMASK 8'h50

// Reset values
`define PDMSC_MASK_CFG_RST    8'h00
`define PDMSC_SLEEP_CFG_RST   8'h00

`endif

// ==== pdmsc_pkg.sv ====
package pdmsc_pkg;

  typedef logic [7:0]  pdmsc_byte_t;
  typedef logic [15:0] pdmsc_word_t;
  typedef logic [13:0] pdmsc_prox_t;

  typedef struct packed {
    pdmsc_byte_t      mask_cfg_r;
    pdmsc_byte_t      sleep_cfg_r;
    logic             sleep_flag_r;
    logic             osc_en_r;
    pdmsc_word_t [3:0] light_latch_r;
    pdmsc_prox_t      prox_r;
    pdmsc_byte_t      rdata_r;
  } pdmsc_state_t;

endpackage

// ==== pdmsc_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module pdmsc_properties (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RST_N,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic       REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  // Power and sleep
  input wire logic       POWER_ON_BIT,
  input wire logic       INT_N,
  input wire logic       CYCLE_END,
  input wire logic       SLEEP_FLAG_CLR,
  // Configuration and sleep status outputs
  input wire logic       EAST_DIODE_DISABLE,
  input wire logic       WEST_DIODE_DISABLE,
  input wire logic       SOUTH_DIODE_DISABLE,
  input wire logic       NORTH_DIODE_DISABLE,
  input wire logic       AMBIENT_PIXEL_REDUCE,
  input wire logic       IR_DIODES_TO_LIGHT_ENGINE,
  input wire logic       SLEEP_AFTER_IRQ,
  input wire logic       SLEEP_LATCHED_FLAG,
  input wire logic       OSC_EN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence sleep_trig;
    SLEEP_AFTER_IRQ && POWER_ON_BIT && !INT_N && CYCLE_END;
  endsequence
  sequence cfg_wr(logic [7:0] a);
    REG_WR && REG_ADDR == a;
  endsequence
  chk_mask_write: assert property (
    cfg_wr(8'h9F) |=> {EAST_DIODE_DISABLE, WEST_DIODE_DISABLE, SOUTH_DIODE_DISABLE,
    NORTH_DIODE_DISABLE, AMBIENT_PIXEL_REDUCE} == $past(REG_WDATA[7:3]))
    else $error("mask outputs differ from written bits");
  chk_route_write: assert property (
    cfg_wr(8'hAB) |=> IR_DIODES_TO_LIGHT_ENGINE == $past(REG_WDATA[6]))
    else $error("routing bit differs from write");
  chk_sai_write: assert property (
    cfg_wr(8'hAB) |=> SLEEP_AFTER_IRQ == $past(REG_WDATA[4]))
    else $error("sleep enable differs from write");
  chk_sleep_entry: assert property (
    sleep_trig |=> SLEEP_LATCHED_FLAG && !OSC_EN)
    else $error("no sleep after interrupt cycle");
  chk_regs_keep: assert property (
    (sleep_trig and !REG_WR) |=> $stable({EAST_DIODE_DISABLE, NORTH_DIODE_DISABLE,
    IR_DIODES_TO_LIGHT_ENGINE, SLEEP_AFTER_IRQ}))
    else $error("config changed on sleep entry");
  chk_sleep_hold: assert property (
    SLEEP_LATCHED_FLAG && !SLEEP_FLAG_CLR |=> SLEEP_LATCHED_FLAG)
    else $error("woke without host clear");
  chk_osc_off: assert property (
    !POWER_ON_BIT |=> !OSC_EN)
    else $error("oscillator runs without power");
  chk_osc_run: assert property (
    POWER_ON_BIT && !SLEEP_AFTER_IRQ |=> OSC_EN)
    else $error("oscillator stopped without sleep mode");
  chk_reserved_zero: assert property (
    REG_RD && REG_ADDR == 8'h9F |=> REG_RDATA[2:0] == 3'h0)
    else $error("reserved bits read nonzero");
endmodule
`default_nettype wire

// ==== pdmsc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pdmsc_map.svh"

module pdmsc_top (
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  // Register access port
  input  wire logic [7:0]            REG_ADDR,
  input  wire logic                  REG_WR,
  input  wire logic [7:0]            REG_WDATA,
  input  wire logic                  REG_RD,
  output logic      [7:0]            REG_RDATA,
  // Light engine channels
  input  wire pdmsc_pkg::pdmsc_word_t COLOR_CLEAR,
  input  wire pdmsc_pkg::pdmsc_word_t COLOR_RED,
  input  wire pdmsc_pkg::pdmsc_word_t COLOR_GREEN,
  input  wire pdmsc_pkg::pdmsc_word_t COLOR_BLUE,
  input  wire pdmsc_pkg::pdmsc_word_t IR_NORTH,
  input  wire pdmsc_pkg::pdmsc_word_t IR_SOUTH,
  input  wire pdmsc_pkg::pdmsc_word_t IR_WEST,
  input  wire pdmsc_pkg::pdmsc_word_t IR_EAST,
  // Proximity diode samples
  input  wire pdmsc_pkg::pdmsc_prox_t PROX_NORTH,
  input  wire pdmsc_pkg::pdmsc_prox_t PROX_SOUTH,
  input  wire pdmsc_pkg::pdmsc_prox_t PROX_WEST,
  input  wire pdmsc_pkg::pdmsc_prox_t PROX_EAST,
  // Power and sleep control
  input  wire logic                  POWER_ON_BIT,
  input  wire logic                  INT_N,
  input  wire logic                  CYCLE_END,
  input  wire logic                  SLEEP_FLAG_CLR,
  // Configuration, sleep status and proximity result outputs
  output logic                       EAST_DIODE_DISABLE,
  output logic                       WEST_DIODE_DISABLE,
  output logic                       SOUTH_DIODE_DISABLE,
  output logic                       NORTH_DIODE_DISABLE,
  output logic                       AMBIENT_PIXEL_REDUCE,
  output logic                       IR_DIODES_TO_LIGHT_ENGINE,
  output logic                       SLEEP_AFTER_IRQ,
  output logic                       SLEEP_LATCHED_FLAG,
  output logic                       OSC_EN,
  output pdmsc_pkg::pdmsc_prox_t     PROXIMITY_RESULT
);
  import pdmsc_pkg::*;

  pdmsc_state_t st_r;
  pdmsc_state_t st_nxt;

  // Address match for the register write decode chain
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  // Mean of enabled diodes
  function automatic pdmsc_prox_t prox_mean(
    input logic [15:0] sum,
    input logic [2:0]  cnt
  );
    logic [15:0] q;
    q = 16'h0000;
    case (cnt)
      3'd1:    q = sum;
      3'd2:    q = sum >> 1;
      3'd3:    q = sum / 16'd3;
      3'd4:    q = sum >> 2;
      default: q = 16'h0000;
    endcase
    return q[13:0];
  endfunction

  logic        dis_e;
  logic        dis_w;
  logic        dis_s;
  logic        dis_n;
  logic        route_ir;
  logic        sleep_after_irq;
  logic        sleep_set;
  logic [15:0] prox_sum;
  logic [2:0]  prox_cnt;
  pdmsc_word_t [3:0] live;

  always_comb begin
    dis_e    = st_r.mask_cfg_r[`PDMSC_BIT_EAST];
    dis_w    = st_r.mask_cfg_r[`PDMSC_BIT_WEST];
    dis_s    = st_r.mask_cfg_r[`PDMSC_BIT_SOUTH];
    dis_n    = st_r.mask_cfg_r[`PDMSC_BIT_NORTH];
    route_ir = st_r.sleep_cfg_r[`PDMSC_BIT_IR_ROUTE];
    sleep_after_irq      = st_r.sleep_cfg_r[`PDMSC_BIT_SLEEP_IRQ];
    // Sleep entry from interrupt at cycle end
    sleep_set = sleep_after_irq && POWER_ON_BIT && !INT_N && CYCLE_END;
    // Channel selection
    if (route_ir) begin
      live[0] = IR_NORTH;
      live[1] = IR_SOUTH;
      live[2] = IR_WEST;
      live[3] = IR_EAST;
    end else begin
      live[0] = COLOR_CLEAR;
      live[1] = COLOR_RED;
      live[2] = COLOR_GREEN;
      live[3] = COLOR_BLUE;
    end
    // Sum of enabled diodes only
    prox_sum = 16'h0000;
    prox_cnt = 3'd0;
    if (!dis_n) begin
      prox_sum = prox_sum + {2'b00, PROX_NORTH};
      prox_cnt = prox_cnt + 3'd1;
    end
    if (!dis_s) begin
      prox_sum = prox_sum + {2'b00, PROX_SOUTH};
      prox_cnt = prox_cnt + 3'd1;
    end
    if (!dis_w) begin
      prox_sum = prox_sum + {2'b00, PROX_WEST};
      prox_cnt = prox_cnt + 3'd1;
    end
    if (!dis_e) begin
      prox_sum = prox_sum + {2'b00, PROX_EAST};
      prox_cnt = prox_cnt + 3'd1;
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.prox_r = prox_mean(prox_sum, prox_cnt);
    // Register writes
    if (REG_WR) begin
      if (addr_hit(REG_ADDR, `PDMSC_OFS_MASK_CFG)) begin
        st_nxt.mask_cfg_r = REG_WDATA & `PDMSC_MASK_CFG_WMASK;
      end else if (addr_hit(REG_ADDR, `PDMSC_OFS_SLEEP_CFG)) begin
        st_nxt.sleep_cfg_r = REG_WDATA & `PDMSC_SLEEP_CFG_WMASK;
      end
    end
    // Sleep flag, set wins over clear
    if (SLEEP_FLAG_CLR) begin
      st_nxt.sleep_flag_r = 1'b0;
    end
    if (sleep_set) begin
      st_nxt.sleep_flag_r = 1'b1;
    end
    // Oscillator gate from power-on, sleep-after-interrupt enable and sleep flag
    st_nxt.osc_en_r = POWER_ON_BIT && !(sleep_after_irq && st_nxt.sleep_flag_r);
    // Register reads
    if (REG_RD) begin
      if (REG_ADDR == `PDMSC_OFS_DATA_C_LO) begin
        st_nxt.light_latch_r = live;
        st_nxt.rdata_r = live[0][7:0];
      end else if (REG_ADDR == `PDMSC_OFS_DATA_C_HI) begin
        st_nxt.rdata_r = st_r.light_latch_r[0][15:8];
      end else if (REG_ADDR == `PDMSC_OFS_DATA_R_LO) begin
        st_nxt.rdata_r = st_r.light_latch_r[1][7:0];
      end else if (REG_ADDR == `PDMSC_OFS_DATA_R_HI) begin
        st_nxt.rdata_r = st_r.light_latch_r[1][15:8];
      end else if (REG_ADDR == `PDMSC_OFS_DATA_G_LO) begin
        st_nxt.rdata_r = st_r.light_latch_r[2][7:0];
      end else if (REG_ADDR == `PDMSC_OFS_DATA_G_HI) begin
        st_nxt.rdata_r = st_r.light_latch_r[2][15:8];
      end else if (REG_ADDR == `PDMSC_OFS_DATA_B_LO) begin
        st_nxt.rdata_r = st_r.light_latch_r[3][7:0];
      end else if (REG_ADDR == `PDMSC_OFS_DATA_B_HI) begin
        st_nxt.rdata_r = st_r.light_latch_r[3][15:8];
      end else if (REG_ADDR == `PDMSC_OFS_PROX_LO) begin
        st_nxt.rdata_r = st_r.prox_r[7:0];
      end else if (REG_ADDR == `PDMSC_OFS_PROX_HI) begin
        st_nxt.rdata_r = {2'b00, st_r.prox_r[13:8]};
      end else if (REG_ADDR == `PDMSC_OFS_MASK_CFG) begin
        st_nxt.rdata_r = st_r.mask_cfg_r;
      end else if (REG_ADDR == `PDMSC_OFS_SLEEP_CFG) begin
        st_nxt.rdata_r = st_r.sleep_cfg_r;
      end else begin
        st_nxt.rdata_r = 8'h00;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r.mask_cfg_r    <= `PDMSC_MASK_CFG_RST;
      st_r.sleep_cfg_r   <= `PDMSC_SLEEP_CFG_RST;
      st_r.sleep_flag_r  <= 1'b0;
      st_r.osc_en_r      <= 1'b0;
      st_r.light_latch_r <= '0;
      st_r.prox_r        <= 14'h0000;
      st_r.rdata_r       <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign REG_RDATA                 = st_r.rdata_r;
  assign EAST_DIODE_DISABLE        = dis_e;
  assign WEST_DIODE_DISABLE        = dis_w;
  assign SOUTH_DIODE_DISABLE       = dis_s;
  assign NORTH_DIODE_DISABLE       = dis_n;
  assign AMBIENT_PIXEL_REDUCE      = st_r.mask_cfg_r[`PDMSC_BIT_AMB_REDUCE];
  assign IR_DIODES_TO_LIGHT_ENGINE = route_ir;
  assign SLEEP_AFTER_IRQ           = sleep_after_irq;
  assign SLEEP_LATCHED_FLAG        = st_r.sleep_flag_r;
  assign OSC_EN                    = st_r.osc_en_r;
  assign PROXIMITY_RESULT          = st_r.prox_r;

endmodule

`default_nettype wire

// ==== photodiode_mask_and_sleep_config_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module photodiode_mask_and_sleep_config_test;
  import pdmsc_pkg::*;
  logic CLK = 0, RST_N = 0, POWER_ON_BIT = 0, INT_N = 1, CYCLE_END = 0;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, rd;
  logic REG_WR, REG_RD, SLEEP_FLAG_CLR, EAST_DIODE_DISABLE, WEST_DIODE_DISABLE;
  logic SOUTH_DIODE_DISABLE, NORTH_DIODE_DISABLE, AMBIENT_PIXEL_REDUCE;
  logic IR_DIODES_TO_LIGHT_ENGINE, SLEEP_AFTER_IRQ, SLEEP_LATCHED_FLAG, OSC_EN;
  pdmsc_word_t COLOR_CLEAR = 16'h1111, COLOR_RED = 16'h2222, COLOR_GREEN = 16'h3333;
  pdmsc_word_t COLOR_BLUE = 16'h4444, IR_NORTH = 16'hA1B1, IR_SOUTH = 16'hA2B2;
  pdmsc_word_t IR_WEST = 16'hA3B3, IR_EAST = 16'hA4B4;
  pdmsc_prox_t PROX_NORTH = 14'h0003, PROX_SOUTH = 14'h0006, PROX_WEST = 14'h0009;
  pdmsc_prox_t PROX_EAST = 14'h000C, PROXIMITY_RESULT;
  int fails = 0, checks_done = 0;
  always #12.5 CLK = ~CLK;
  pdmsc_top dut (.CLK, .RST_N, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA,
    .COLOR_CLEAR, .COLOR_RED, .COLOR_GREEN, .COLOR_BLUE, .IR_NORTH, .IR_SOUTH, .IR_WEST,
    .IR_EAST, .PROX_NORTH, .PROX_SOUTH, .PROX_WEST, .PROX_EAST, .POWER_ON_BIT, .INT_N,
    .CYCLE_END, .SLEEP_FLAG_CLR, .EAST_DIODE_DISABLE, .WEST_DIODE_DISABLE,
    .SOUTH_DIODE_DISABLE, .NORTH_DIODE_DISABLE, .AMBIENT_PIXEL_REDUCE,
    .IR_DIODES_TO_LIGHT_ENGINE, .SLEEP_AFTER_IRQ, .SLEEP_LATCHED_FLAG, .OSC_EN,
    .PROXIMITY_RESULT);
  pdmsc_host host (.CLK, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA,
    .SLEEP_FLAG_CLR);
  task t_mask;
    @(negedge CLK) `CHK(PROXIMITY_RESULT, 14'h0007)
    host.wr(8'h9F, 8'h80);
    @(negedge CLK) `CHK(PROXIMITY_RESULT, 14'h0006)
    host.wr(8'h9F, 8'hF8);
    `CHK({EAST_DIODE_DISABLE, WEST_DIODE_DISABLE, SOUTH_DIODE_DISABLE, NORTH_DIODE_DISABLE,
      AMBIENT_PIXEL_REDUCE}, 5'h1F)
    host.rd(8'h9F, rd); `CHK(rd, 8'hF8)
    `CHK(PROXIMITY_RESULT, 14'h0000)
    host.wr(8'h9F, 8'h50);
    `CHK({EAST_DIODE_DISABLE, WEST_DIODE_DISABLE, SOUTH_DIODE_DISABLE, NORTH_DIODE_DISABLE,
      AMBIENT_PIXEL_REDUCE}, 5'h0A)
    host.rd(8'h9C, rd); `CHK(rd, 8'h09)
    `CHK(PROXIMITY_RESULT, 14'h0009)
    $display("mask test done");
  endtask
  task t_route;
    host.wr(8'hAB, 8'h50); host.rd(8'hAB, rd); `CHK(rd, 8'h50)
    `CHK(IR_DIODES_TO_LIGHT_ENGINE, 1'h1)
    host.rd(8'h94, rd); `CHK(rd, 8'hB1)
    host.rd(8'h9B, rd); `CHK(rd, 8'hA4)
    host.wr(8'hAB, 8'h00); host.rd(8'h94, rd); `CHK(rd, 8'h11)
    host.rd(8'h99, rd); `CHK(rd, 8'h33)
    host.rd(8'h77, rd); `CHK(rd, 8'h00)
    $display("route test done");
  endtask
  task t_sleep;
    @(negedge CLK) POWER_ON_BIT = 1;
    @(negedge CLK) `CHK(OSC_EN, 1'h1)
    {INT_N, CYCLE_END} = 2'h1;
    @(negedge CLK) CYCLE_END = 0;
    INT_N = 1;
    `CHK({SLEEP_LATCHED_FLAG, OSC_EN}, 2'h1)
    host.wr(8'hAB, 8'h10); `CHK(SLEEP_AFTER_IRQ, 1'h1)
    `CHK(OSC_EN, 1'h1)
    @(negedge CLK) {INT_N, CYCLE_END} = 2'h1;
    @(negedge CLK) CYCLE_END = 0;
    `CHK({SLEEP_LATCHED_FLAG, OSC_EN, NORTH_DIODE_DISABLE}, 3'h5)
    repeat (5) @(negedge CLK);
    INT_N = 1;
    @(negedge CLK) `CHK({SLEEP_LATCHED_FLAG, OSC_EN}, 2'h2)
    host.clr; `CHK({SLEEP_LATCHED_FLAG, OSC_EN}, 2'h1)
    @(negedge CLK) POWER_ON_BIT = 0;
    @(negedge CLK) `CHK(OSC_EN, 1'h0)
    $display("sleep test done");
  endtask
  task t_reset;
    @(negedge CLK) POWER_ON_BIT = 1;
    @(negedge CLK) RST_N = 0;
    @(negedge CLK) `CHK({NORTH_DIODE_DISABLE, SLEEP_AFTER_IRQ, OSC_EN}, 3'h0)
    RST_N = 1;
    host.rd(8'h9F, rd); `CHK(rd, 8'h00)
    `CHK(OSC_EN, 1'h1)
    $display("reset test done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge CLK);
    RST_N = 1;
    t_mask;
    t_route;
    t_sleep;
    t_reset;
    final_report;
  end
  initial begin
    #100000;
    fails++;
    final_report;
  end
endmodule
bind pdmsc_top pdmsc_properties chk (.CLK, .RST_N, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD,
  .REG_RDATA, .POWER_ON_BIT, .INT_N, .CYCLE_END, .SLEEP_FLAG_CLR, .EAST_DIODE_DISABLE,
  .WEST_DIODE_DISABLE, .SOUTH_DIODE_DISABLE, .NORTH_DIODE_DISABLE, .AMBIENT_PIXEL_REDUCE,
  .IR_DIODES_TO_LIGHT_ENGINE, .SLEEP_AFTER_IRQ, .SLEEP_LATCHED_FLAG, .OSC_EN);
`default_nettype wire
